// [pkg/cfdr_pkg.sv]
`default_nettype none
package cfdr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK = 8'h08;
   localparam logic [7:0] OFS_STATE = 8'h0c;

   // Clock source codes
   localparam logic [1:0] SRC_PRIMARY = 2'h0;
   localparam logic [1:0] SRC_WDT = 2'h1;

   // Status, mask and state bit positions
   localparam int BIT_SYS_FAIL = 0;
   localparam int BIT_WDT_FAIL = 1;
   localparam int BIT_WDT_DEAD = 0;
   localparam int BIT_ON_WDT = 1;

   // Timing
   localparam int MCLK_PERIOD_NS = 100;
   localparam int SYS_FAIL_PERIOD_NS = 1000000;
   localparam int SYS_FAIL_CYCLES = SYS_FAIL_PERIOD_NS / MCLK_PERIOD_NS;
   localparam int WDT_FAIL_SYS_CLOCKS = 8004;

   typedef struct packed {
      logic [1:0] clock_source_select;
      logic wdt_osc_en;
      logic wdt_osc_fail_detect_en;
      logic sysclk_fail_detect_en;
   } osc_ctrl_t;

   localparam osc_ctrl_t OSC_CTRL_RESET = '{
      clock_source_select: SRC_PRIMARY,
      wdt_osc_en: 1'b1,
      wdt_osc_fail_detect_en: 1'b0,
      sysclk_fail_detect_en: 1'b0
   };
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic read;
   } bus_phase_t;
endpackage
`default_nettype wire

// [rtl/clock_failure_detect_recover.sv]
`timescale 1ns/100ps
`default_nettype none
module clock_failure_detect_recover #(
   parameter int CNT_W = 16,
   parameter int SYS_FAIL_LIMIT = cfdr_pkg::SYS_FAIL_CYCLES,
   parameter int WDT_FAIL_LIMIT = cfdr_pkg::WDT_FAIL_SYS_CLOCKS
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic primary_osc_clk,
   input wire logic wdt_osc_clk,
   output logic [1:0] clock_source_select,
   output logic wdt_osc_enable,
   output logic irq
);
   // Pin synchronisers: stage 1 feeds only stage 2
   logic [2:0] prim_sync;
   logic [2:0] wdt_sync;
   logic [2:0] next_prim_sync;
   logic [2:0] next_wdt_sync;
   logic prim_edge;
   logic wdt_edge;

   cfdr_pkg::osc_ctrl_t oscillator_control_reg;
   cfdr_pkg::osc_ctrl_t next_ctrl;
   logic [1:0] clock_fail_status;
   logic [1:0] next_status;
   logic [1:0] clock_fail_mask;
   logic [1:0] next_mask;
   logic wdt_dead;
   logic next_wdt_dead;
   logic [CNT_W-1:0] sys_cnt;
   logic [CNT_W-1:0] next_sys_cnt;
   logic [CNT_W-1:0] wdt_cnt;
   logic [CNT_W-1:0] next_wdt_cnt;
   logic sys_det_active;
   logic wdt_det_active;
   logic sys_fail_evt;
   logic wdt_fail_evt;

   cfdr_pkg::bus_phase_t dphase;
   cfdr_pkg::bus_phase_t next_dphase;
   logic [31:0] next_hrdata;
   logic next_irq;
   logic wr_ctrl;
   logic wr_status;
   logic wr_mask;
   logic addr_ok;

   localparam logic [CNT_W-1:0] SYS_LAST = CNT_W'(SYS_FAIL_LIMIT - 1);
   localparam logic [CNT_W-1:0] SYS_HOLD = CNT_W'(SYS_FAIL_LIMIT);
   localparam logic [CNT_W-1:0] WDT_LAST = CNT_W'(WDT_FAIL_LIMIT - 1);
   localparam logic [CNT_W-1:0] WDT_HOLD = CNT_W'(WDT_FAIL_LIMIT);

   always_comb begin
      next_prim_sync = {prim_sync[1:0], primary_osc_clk};
      next_wdt_sync = {wdt_sync[1:0], wdt_osc_clk};
      prim_edge = prim_sync[1] & ~prim_sync[2];
      wdt_edge = wdt_sync[1] & ~wdt_sync[2];
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         prim_sync <= 3'h0;
         wdt_sync <= 3'h0;
      end else if (ce) begin
         prim_sync <= next_prim_sync;
         wdt_sync <= next_wdt_sync;
      end
   end

   // Failure detectors
   always_comb begin
      sys_det_active = oscillator_control_reg.sysclk_fail_detect_en
         & ~wdt_dead
         & (oscillator_control_reg.clock_source_select
            != cfdr_pkg::SRC_WDT);
      wdt_det_active = oscillator_control_reg.wdt_osc_fail_detect_en
         & oscillator_control_reg.wdt_osc_en
         & (oscillator_control_reg.clock_source_select
            != cfdr_pkg::SRC_WDT);
      // Primary clock period measured in mclk cycles
      if (!sys_det_active || prim_edge) begin
         next_sys_cnt = '0;
      end else if (sys_cnt != SYS_HOLD) begin
         next_sys_cnt = sys_cnt + 1'b1;
      end else begin
         next_sys_cnt = sys_cnt;
      end
      sys_fail_evt = ce & sys_det_active & ~prim_edge
         & (sys_cnt == SYS_LAST);
      // System clock edges counted while waiting for a watchdog edge
      if (!wdt_det_active || wdt_edge) begin
         next_wdt_cnt = '0;
      end else if (prim_edge && wdt_cnt != WDT_HOLD) begin
         next_wdt_cnt = wdt_cnt + 1'b1;
      end else begin
         next_wdt_cnt = wdt_cnt;
      end
      wdt_fail_evt = ce & wdt_det_active & ~wdt_edge & prim_edge
         & (wdt_cnt == WDT_LAST);
      next_wdt_dead = wdt_dead | wdt_fail_evt;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sys_cnt <= '0;
         wdt_cnt <= '0;
         wdt_dead <= 1'b0;
      end else if (ce) begin
         sys_cnt <= next_sys_cnt;
         wdt_cnt <= next_wdt_cnt;
         wdt_dead <= next_wdt_dead;
      end
   end

   // AHB-Lite slave, zero wait states
   always_comb begin
      addr_ok = (haddr[7:0] == cfdr_pkg::OFS_OSC_CTRL)
         | (haddr[7:0] == cfdr_pkg::OFS_STATUS)
         | (haddr[7:0] == cfdr_pkg::OFS_MASK)
         | (haddr[7:0] == cfdr_pkg::OFS_STATE);
      next_dphase.addr = haddr[7:0];
      next_dphase.write = hsel & htrans[1] & hready & hwrite
         & (haddr[31:8] == 24'h0);
      next_dphase.read = hsel & htrans[1] & hready & ~hwrite;
      next_hrdata = 32'h0;
      if (next_dphase.read && addr_ok && haddr[31:8] == 24'h0) begin
         unique case (haddr[7:0])
            cfdr_pkg::OFS_OSC_CTRL: next_hrdata = {27'h0,
               oscillator_control_reg};
            cfdr_pkg::OFS_STATUS: next_hrdata = {30'h0,
               clock_fail_status};
            cfdr_pkg::OFS_MASK: next_hrdata = {30'h0, clock_fail_mask};
            default: next_hrdata = {30'h0,
               oscillator_control_reg.clock_source_select
               == cfdr_pkg::SRC_WDT, wdt_dead};
         endcase
      end
      wr_ctrl = dphase.write & (dphase.addr == cfdr_pkg::OFS_OSC_CTRL);
      wr_status = dphase.write & (dphase.addr == cfdr_pkg::OFS_STATUS);
      wr_mask = dphase.write & (dphase.addr == cfdr_pkg::OFS_MASK);
   end

   // Registers, hardware updates win over software writes
   always_comb begin
      next_ctrl = oscillator_control_reg;
      if (wr_ctrl) begin
         next_ctrl = cfdr_pkg::osc_ctrl_t'(hwdata[4:0]);
      end
      if (sys_fail_evt && oscillator_control_reg.wdt_osc_en) begin
         next_ctrl.clock_source_select = cfdr_pkg::SRC_WDT;
      end
      next_status = clock_fail_status;
      if (wr_status) begin
         next_status = clock_fail_status & ~hwdata[1:0];
      end
      next_status[cfdr_pkg::BIT_SYS_FAIL] =
         next_status[cfdr_pkg::BIT_SYS_FAIL] | sys_fail_evt;
      next_status[cfdr_pkg::BIT_WDT_FAIL] =
         next_status[cfdr_pkg::BIT_WDT_FAIL] | wdt_fail_evt;
      next_mask = wr_mask ? hwdata[1:0] : clock_fail_mask;
      next_irq = |(next_status & next_mask);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         oscillator_control_reg <= cfdr_pkg::OSC_CTRL_RESET;
         clock_fail_status <= cfdr_pkg::STATUS_RESET;
         clock_fail_mask <= cfdr_pkg::MASK_RESET;
         dphase <= '0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= 1'b0;
         clock_source_select <= cfdr_pkg::SRC_PRIMARY;
         wdt_osc_enable <= 1'b1;
      end else if (ce) begin
         oscillator_control_reg <= next_ctrl;
         clock_fail_status <= next_status;
         clock_fail_mask <= next_mask;
         dphase <= next_dphase;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= next_irq;
         clock_source_select <= next_ctrl.clock_source_select;
         wdt_osc_enable <= next_ctrl.wdt_osc_en;
      end
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_sys_fail;
      sys_fail_evt;
   endsequence

   sequence s_switched;
      ##1 clock_source_select == cfdr_pkg::SRC_WDT;
   endsequence

   property p_sys_fail_flag;
      s_sys_fail |=> clock_fail_status[cfdr_pkg::BIT_SYS_FAIL];
   endproperty
   a_sys_fail_flag: assert property (p_sys_fail_flag)
      else $error("primary failure not flagged");

   property p_switch_over;
      s_sys_fail and oscillator_control_reg.wdt_osc_en |-> s_switched;
   endproperty
   a_switch_over: assert property (p_switch_over)
      else $error("no switch to watchdog oscillator");

   property p_no_switch_disabled;
      sys_fail_evt && !oscillator_control_reg.wdt_osc_en && !wr_ctrl
         |=> $stable(clock_source_select);
   endproperty
   a_no_switch_disabled: assert property (p_no_switch_disabled)
      else $error("switch while watchdog oscillator disabled");

   property p_sys_threshold;
      sys_fail_evt |-> sys_cnt == SYS_LAST && !prim_edge;
   endproperty
   a_sys_threshold: assert property (p_sys_threshold)
      else $error("primary failure at wrong count");

   property p_wdt_no_switch;
      wdt_fail_evt && !wr_ctrl
         |=> clock_fail_status[cfdr_pkg::BIT_WDT_FAIL]
         && $stable(clock_source_select);
   endproperty
   a_wdt_no_switch: assert property (p_wdt_no_switch)
      else $error("watchdog failure mishandled");

   property p_dead_blocks;
      wdt_dead |=> !$rose(clock_fail_status[cfdr_pkg::BIT_SYS_FAIL])
         && !sys_fail_evt;
   endproperty
   a_dead_blocks: assert property (p_dead_blocks)
      else $error("primary failure after watchdog failure");

   property p_wdt_idle;
      (oscillator_control_reg.clock_source_select == cfdr_pkg::SRC_WDT
         || !oscillator_control_reg.wdt_osc_en) |-> !wdt_fail_evt;
   endproperty
   a_wdt_idle: assert property (p_wdt_idle)
      else $error("watchdog detector active when it must idle");

   property p_wdt_count;
      wdt_fail_evt |-> wdt_cnt == WDT_LAST && prim_edge;
   endproperty
   a_wdt_count: assert property (p_wdt_count)
      else $error("watchdog failure at wrong count");

   property p_wdt_restart;
      ce && wdt_edge |=> wdt_cnt == '0;
   endproperty
   a_wdt_restart: assert property (p_wdt_restart)
      else $error("watchdog counter not restarted");

   property p_irq;
      ce |=> irq == |(clock_fail_status & clock_fail_mask);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt out of step with status");
endmodule
`default_nettype wire

// [bench/osc_source.sv]
`timescale 1ns/100ps
`default_nettype none
module osc_source (
   input wire logic mclk,
   input wire logic pri_run,
   input wire logic wdt_run,
   input wire logic wdt_osc_enable,
   output logic primary_osc_clk,
   output logic wdt_osc_clk
);
   logic [2:0] div;
   initial begin
      div = 3'h0;
      primary_osc_clk = 1'b0;
      wdt_osc_clk = 1'b0;
   end
   // A stopped or disabled source freezes, as a dead oscillator does
   always @(posedge mclk) begin
      div <= div + 3'h1;
      if (pri_run && div[0]) begin
         primary_osc_clk <= ~primary_osc_clk;
      end
      if (wdt_run && wdt_osc_enable && div == 3'h7) begin
         wdt_osc_clk <= ~wdt_osc_clk;
      end
   end
endmodule
`default_nettype wire

// [bench/clock_failure_detect_recover_test.sv]
`timescale 1ns/100ps
`default_nettype none
module clock_failure_detect_recover_test;
   localparam logic [7:0] CTRL = cfdr_pkg::OFS_OSC_CTRL;
   localparam logic [7:0] STAT = cfdr_pkg::OFS_STATUS;
   localparam logic [7:0] MASK = cfdr_pkg::OFS_MASK;
   localparam logic [7:0] STATE = cfdr_pkg::OFS_STATE;
   logic mclk, rst, hsel, hwrite, hready_out, hresp, irq;
   logic pri_run, wdt_run, pri_clk, wdt_clk, wdt_en, ce;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, sel;
   logic [2:0] hsize;
   int n_mismatch, n_compared, cycles;
   clock_failure_detect_recover #(.SYS_FAIL_LIMIT(40), .WDT_FAIL_LIMIT(20))
   clock_failure_detect_recover_i (.mclk(mclk), .rst(rst), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hready_out), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hready_out), .hresp(hresp),
      .primary_osc_clk(pri_clk), .wdt_osc_clk(wdt_clk),
      .clock_source_select(sel), .wdt_osc_enable(wdt_en), .irq(irq));
   osc_source osc_source_i (.mclk(mclk), .pri_run(pri_run),
      .wdt_run(wdt_run), .wdt_osc_enable(wdt_en),
      .primary_osc_clk(pri_clk), .wdt_osc_clk(wdt_clk));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic wrap_up;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         wrap_up;
      end
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Single AHB-Lite word transfer, entered just after a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge mclk);
      while (hready_out !== 1'b1) @(posedge mclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge mclk);
      while (hready_out !== 1'b1) @(posedge mclk);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic wait_irq(input logic e);
      for (int i = 0; i < 300 && irq !== e; i++) @(posedge mclk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pri_run = 1'b1;
      wdt_run = 1'b1;
      n_mismatch = 0;
      n_compared = 0;
      cycles = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd_chk("ctrl", CTRL, 32'h4);
      rd_chk("status", STAT, 32'h0);
      rd_chk("mask", MASK, 32'h0);
      rd_chk("state", STATE, 32'h0);
      xfer(1'b1, 8'h10, 32'hff);
      rd_chk("unmapped", 8'h10, 32'h0);
      xfer(1'b1, MASK, 32'h3);
      xfer(1'b1, CTRL, 32'h5);
      repeat (200) @(posedge mclk);
      rd_chk("status", STAT, 32'h0);
      // Clock enable low freezes the detector although the clock is gone
      ce <= 1'b0;
      pri_run <= 1'b0;
      repeat (100) @(posedge mclk);
      chk("frozen irq", 32'h0, {31'h0, irq});
      ce <= 1'b1;
      rd_chk("status", STAT, 32'h0);
      repeat (20) @(posedge mclk);
      rd_chk("status", STAT, 32'h0);
      wait_irq(1'b1);
      chk("select", {30'h0, cfdr_pkg::SRC_WDT}, {30'h0, sel});
      rd_chk("status", STAT, 32'h1);
      rd_chk("state", STATE, 32'h2);
      xfer(1'b1, STAT, 32'h1);
      wait_irq(1'b0);
      xfer(1'b1, CTRL, 32'hc);
      xfer(1'b1, CTRL, 32'h4);
      pri_run <= 1'b1;
      @(posedge mclk);
      chk("select", 32'h0, {30'h0, sel});
      // Watchdog oscillator disabled: failure flagged, no switch-over
      xfer(1'b1, CTRL, 32'h1);
      pri_run <= 1'b0;
      wait_irq(1'b1);
      chk("wdt_en", 32'h0, {31'h0, wdt_en});
      chk("select", 32'h0, {30'h0, sel});
      xfer(1'b1, CTRL, 32'h0);
      pri_run <= 1'b1;
      xfer(1'b1, STAT, 32'h1);
      xfer(1'b1, CTRL, 32'h2);
      repeat (150) @(posedge mclk);
      rd_chk("status", STAT, 32'h0);
      xfer(1'b1, CTRL, 32'h4);
      xfer(1'b1, CTRL, 32'h6);
      repeat (200) @(posedge mclk);
      rd_chk("status", STAT, 32'h0);
      xfer(1'b1, MASK, 32'h1);
      wdt_run <= 1'b0;
      repeat (40) @(posedge mclk);
      rd_chk("status", STAT, 32'h0);
      repeat (110) @(posedge mclk);
      rd_chk("status", STAT, 32'h2);
      chk("irq masked", 32'h0, {31'h0, irq});
      chk("select", 32'h0, {30'h0, sel});
      rd_chk("state", STATE, 32'h1);
      xfer(1'b1, MASK, 32'h3);
      wait_irq(1'b1);
      xfer(1'b1, STAT, 32'h2);
      wait_irq(1'b0);
      xfer(1'b1, CTRL, 32'h5);
      pri_run <= 1'b0;
      repeat (150) @(posedge mclk);
      rd_chk("status", STAT, 32'h0);
      chk("select", 32'h0, {30'h0, sel});
      // Second reset clears the sticky watchdog failure
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd_chk("state", STATE, 32'h0);
      rd_chk("ctrl", CTRL, 32'h4);
      // Stopped primary stands for a very slow clock, detect left off
      repeat (150) @(posedge mclk);
      rd_chk("status", STAT, 32'h0);
      chk("select", 32'h0, {30'h0, sel});
      wrap_up;
   end
endmodule
`default_nettype wire
